// ### common/dps_pkg.sv
// Types for the dual-port semaphore host controller
`include "dps_regs.svh"
package dps_pkg;
  typedef enum logic [1:0] {CMD_ACQUIRE, CMD_RELEASE, CMD_TEST, CMD_INIT} dps_cmd_e;
  typedef enum {ST_IDLE, ST_WR, ST_GAP, ST_RD, ST_DONE} dps_state_e;
  typedef struct packed {
    logic semaphore_select_n;
    logic oe_n;
    logic rw_n;
    logic [`DPS_ADDR_W-1:0] addr;
    logic [`DPS_DATA_W-1:0] dout;
    logic dout_en;
  } dps_pins_s;
  typedef struct packed {
    dps_state_e state;
    dps_cmd_e cmd;
    logic [`DPS_IDX_W-1:0] idx;
    logic [3:0] cnt;
    logic owned;
    logic done;
    logic init_pass;
    dps_pins_s pins;
  } dps_state_s;
endpackage

// ### common/dps_regs.svh
// Constants for the dual-port semaphore host controller
// What this block does
// - Write zero requests, write one releases
// - Select low, then ordinary SRAM-style access
// - Deassert select or enable between reads
// - Write zero first, then read to confirm
// - After failure, reread or write one; the block only returns owned low and leaves a TEST or RELEASE to the caller
// - Software initialises flags to one, from the given flag up to the last
`ifndef DPS_REGS_SVH
`define DPS_REGS_SVH
`define DPS_NUM_FLAGS 8
`define DPS_IDX_W 3
`define DPS_ADDR_W 13
`define DPS_DATA_W 16
`define DPS_REQ_ZERO 1'b0
`define DPS_REL_ONE 1'b1
`define DPS_STEP_CYCLES 4'h2
`endif

// ### rtl/dps_host.sv
// Host-side controller driving one port's semaphore pins
`include "dps_regs.svh"
module dps_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Command port
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dps_pkg::dps_cmd_e cmd_op,
  input wire logic [`DPS_IDX_W-1:0] cmd_idx,
  output logic done,
  output logic owned,
  // Device pins
  output dps_pkg::dps_pins_s pins,
  input wire logic [`DPS_DATA_W-1:0] data_in
);
  // ==========================================
  // State
  dps_pkg::dps_state_s st, next_st;

  function automatic logic [`DPS_DATA_W-1:0] wr_word(input logic b);
    wr_word = {`DPS_DATA_W{b}};
  endfunction

  assign cmd_ready = (st.state == dps_pkg::ST_IDLE);
  assign done = st.done;
  assign owned = st.owned;
  assign pins = st.pins;

  // ==========================================
  // Sequencer
  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    case (st.state)
      dps_pkg::ST_IDLE: begin
        next_st.pins.semaphore_select_n = 1'b1;
        next_st.pins.oe_n = 1'b1;
        next_st.pins.rw_n = 1'b1;
        next_st.pins.dout_en = 1'b0;
        if (cmd_valid) begin
          next_st.cmd = cmd_op;
          next_st.idx = cmd_idx;
          next_st.init_pass = 1'b0;
          next_st.cnt = `DPS_STEP_CYCLES;
          next_st.pins.addr = {{(`DPS_ADDR_W-`DPS_IDX_W){1'b0}}, cmd_idx};
          if (cmd_op == dps_pkg::CMD_TEST) begin
            next_st.pins.semaphore_select_n = 1'b0;
            next_st.pins.oe_n = 1'b0;
            next_st.state = dps_pkg::ST_RD;
          end else begin
            next_st.pins.semaphore_select_n = 1'b0;
            next_st.pins.rw_n = 1'b0;
            next_st.pins.dout_en = 1'b1;
            // Acquire writes zero, release and init write one
            next_st.pins.dout = wr_word(cmd_op == dps_pkg::CMD_ACQUIRE ?
              `DPS_REQ_ZERO : `DPS_REL_ONE);
            next_st.state = dps_pkg::ST_WR;
          end
        end
      end
      dps_pkg::ST_WR: begin
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1) begin
          next_st.pins.semaphore_select_n = 1'b1;
          next_st.pins.rw_n = 1'b1;
          next_st.pins.dout_en = 1'b0;
          next_st.cnt = `DPS_STEP_CYCLES;
          next_st.state = dps_pkg::ST_GAP;
        end
      end
      dps_pkg::ST_GAP: begin
        // Gap guarantees a fresh output-register capture
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1) begin
          next_st.cnt = `DPS_STEP_CYCLES;
          if (st.cmd == dps_pkg::CMD_INIT && st.idx != 3'(`DPS_NUM_FLAGS - 1)) begin
            next_st.idx = st.idx + 3'h1;
            next_st.pins.addr = {{(`DPS_ADDR_W-`DPS_IDX_W){1'b0}}, st.idx + 3'h1};
            next_st.pins.semaphore_select_n = 1'b0;
            next_st.pins.rw_n = 1'b0;
            next_st.pins.dout_en = 1'b1;
            next_st.state = dps_pkg::ST_WR;
          end else if (st.cmd == dps_pkg::CMD_ACQUIRE) begin
            next_st.pins.semaphore_select_n = 1'b0;
            next_st.pins.oe_n = 1'b0;
            next_st.state = dps_pkg::ST_RD;
          end else begin
            if (st.cmd == dps_pkg::CMD_RELEASE) begin
              next_st.owned = 1'b0;
            end
            next_st.done = 1'b1;
            next_st.state = dps_pkg::ST_IDLE;
          end
        end
      end
      dps_pkg::ST_RD: begin
        next_st.cnt = st.cnt - 4'h1;
        if (st.cnt == 4'h1) begin
          // Zero read back means this side owns the token
          next_st.owned = ~data_in[0];
          next_st.pins.semaphore_select_n = 1'b1;
          next_st.pins.oe_n = 1'b1;
          next_st.done = 1'b1;
          next_st.state = dps_pkg::ST_IDLE;
        end
      end
      default: next_st.state = dps_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '{state: dps_pkg::ST_IDLE, cmd: dps_pkg::CMD_TEST, idx: 3'h0, cnt: 4'h0,
        owned: 1'b0, done: 1'b0, init_pass: 1'b0,
        pins: '{semaphore_select_n: 1'b1, oe_n: 1'b1, rw_n: 1'b1, addr: 13'h0000,
        dout: 16'h0000, dout_en: 1'b0}};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================
  // Checks
  // Pin-level sanity: a strobe never floats outside the semaphore select
  chk_no_read_write: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !(pins.oe_n == 1'b0 && pins.rw_n == 1'b0))
    else $error("oe and write together");

  chk_write_selected: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !pins.rw_n |-> !pins.semaphore_select_n)
    else $error("write strobe without select");

  chk_read_selected: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !pins.oe_n |-> !pins.semaphore_select_n)
    else $error("read strobe without select");

  chk_data_en_write: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    pins.dout_en == !pins.rw_n)
    else $error("data driven outside write");

  chk_addr_high_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !pins.semaphore_select_n |-> pins.addr[12:3] == 10'h000)
    else $error("high address bits set");

  chk_data_uniform: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !pins.rw_n |-> (pins.dout == 16'h0000 || pins.dout == 16'hffff))
    else $error("mixed write word");

  // ==========================================
  // Command sequencing
  chk_acq_writes_zero: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_ACQUIRE
    |=> pins.dout == 16'h0000 && !pins.rw_n)
    else $error("acquire not zero write");

  chk_rel_writes_one: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_RELEASE |=> pins.dout == 16'hffff)
    else $error("release not one write");

  chk_release_clears: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_RELEASE |-> ##5 done && !owned)
    else $error("release did not drop ownership");

  // Select or enable must drop between reads or the device output register never refreshes; this checks select
  chk_read_gap: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    $rose(pins.oe_n) |-> pins.semaphore_select_n)
    else $error("select held over reads");

  chk_idle_released: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_ready |-> pins.semaphore_select_n && pins.oe_n && pins.rw_n)
    else $error("pins active while idle");

  chk_done_pulse: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    done |=> !done)
    else $error("done longer than one cycle");

  chk_write_then_read: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_ACQUIRE |=> !pins.rw_n [*2]
    ##1 pins.semaphore_select_n [*2] ##1 !pins.oe_n)
    else $error("acquire order");

  chk_acq_latency: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_ACQUIRE |-> ##7 done)
    else $error("acquire latency");

  chk_test_latency: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_TEST
    |=> !pins.oe_n && pins.rw_n ##2 done && pins.semaphore_select_n)
    else $error("test read sequence");

  // Ownership is only ever taken from a read, never assumed from the write
  chk_owned_from_read: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    st.state == dps_pkg::ST_RD && st.cnt == 4'h1 |=> owned == ~$past(data_in[0]) && done)
    else $error("ownership not from read");

  chk_init_ones: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !pins.rw_n && st.cmd == dps_pkg::CMD_INIT |-> pins.dout == 16'hffff)
    else $error("init not one");

  // Init walks from the given flag up to the last, so from flag 0 it is the slowest command by far
  chk_init_latency: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    cmd_valid && cmd_ready && cmd_op == dps_pkg::CMD_INIT |-> ##33 done)
    else $error("init latency");
endmodule

// ### tb/dps_host_bench.sv
// Self-checking bench: two hosts sharing one semaphore model
module dps_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Signals; a row is side, command, flag, expected ownership
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid [2] = '{1'b0, 1'b0};
  dps_pkg::dps_cmd_e cmd_op [2] = '{dps_pkg::CMD_TEST, dps_pkg::CMD_TEST};
  logic [2:0] cmd_idx [2] = '{3'h0, 3'h0};
  logic cmd_ready [2], done [2], owned [2];
  dps_pkg::dps_pins_s pins [2];
  logic [15:0] rdata [2];
  int n_errors = 0;
  int tests_run = 0;
  int lat [4] = '{7, 5, 3, 33};
  logic [6:0] rows [16] = '{7'h30, 7'h70, 7'h01, 7'h40, 7'h60, 7'h10, 7'h61, 7'h20,
    7'h50, 7'h4f, 7'h0e, 7'h1e, 7'h5e, 7'h0f, 7'h6e, 7'h1e};
  dps_host i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid[0]),
    .cmd_ready(cmd_ready[0]), .cmd_op(cmd_op[0]), .cmd_idx(cmd_idx[0]), .done(done[0]),
    .owned(owned[0]), .pins(pins[0]), .data_in(rdata[0]));
  dps_host i_peer (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid[1]),
    .cmd_ready(cmd_ready[1]), .cmd_op(cmd_op[1]), .cmd_idx(cmd_idx[1]), .done(done[1]),
    .owned(owned[1]), .pins(pins[1]), .data_in(rdata[1]));
  dps_sem_model i_dev (.sys_clk(sys_clk), .pins(pins), .rdata(rdata));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask
  task automatic cmd(input logic [6:0] r);
    int s = int'(r[6]);
    int n = 0;
    @(posedge sys_clk);
    cmd_valid[s] <= 1'b1;
    cmd_op[s] <= dps_pkg::dps_cmd_e'(r[5:4]);
    cmd_idx[s] <= r[3:1];
    @(posedge sys_clk);
    cmd_valid[s] <= 1'b0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (done[s] !== 1'b1 && n < 60);
    chk(n == lat[r[5:4]], "command latency");
    if (r[5:4] != 2'h3) chk(owned[s] === r[0], "ownership");
    $display("test %h ended", r);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rows[k]) cmd(rows[k]);
    // Same-edge requests on one flag
    fork
      cmd(7'h0b);
      cmd(7'h4a);
    join
    chk((owned[0] ^ owned[1]) === 1'b1, "one winner");
    cmd(7'h1a);
    cmd(7'h6b);
    cmd(7'h5a);
    // Reset in mid-acquire leaves a stale request behind
    @(posedge sys_clk);
    cmd_valid[0] <= 1'b1;
    cmd_op[0] <= dps_pkg::CMD_ACQUIRE;
    cmd_idx[0] <= 3'h2;
    @(posedge sys_clk);
    cmd_valid[0] <= 1'b0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(negedge sys_clk);
    chk(pins[0].semaphore_select_n === 1'b1 && pins[0].rw_n === 1'b1
      && pins[0].dout_en === 1'b0 && owned[0] === 1'b0 && cmd_ready[0] === 1'b1, "reset");
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    cmd(7'h14);
    cmd(7'h45);
    cmd(7'h54);
    tally_and_finish;
  end
  initial begin
    #(40 * 5000);
    n_errors++;
    $display("ERROR %0t watchdog", $time);
    tally_and_finish;
  end
endmodule

// ### tb/dps_sem_model.sv
// Behavioural two-port semaphore device facing both hosts
module dps_sem_model (
  // Clock
  input wire logic sys_clk,
  // Port pins and read data, left then right
  input wire dps_pkg::dps_pins_s pins [2],
  output logic [15:0] rdata [2]
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====
  // Flag state, own: 0 free, 1 left, 2 right
  // No power-up reset: both sides start requesting, so init must clear it
  logic [7:0] req [2] = '{8'h00, 8'h00};
  logic [1:0] own [8] = '{default: 2'h1};
  logic [15:0] lat [2] = '{16'h0000, 16'h0000};
  logic rd_q [2] = '{1'b0, 1'b0};
  logic rd;
  // Flags only feed read data, never gate anything
  always @(posedge sys_clk) begin
    for (int s = 0; s < 2; s++) begin
      if (!pins[s].semaphore_select_n && !pins[s].rw_n) begin
        req[s][pins[s].addr[2:0]] = pins[s].dout[0];
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (own[i] == 2'h1 && req[0][i]) own[i] = req[1][i] ? 2'h0 : 2'h2;
      if (own[i] == 2'h2 && req[1][i]) own[i] = req[0][i] ? 2'h0 : 2'h1;
      // Left wins a same-edge tie
      if (own[i] == 2'h0) own[i] = !req[0][i] ? 2'h1 : (!req[1][i] ? 2'h2 : 2'h0);
    end
    for (int s = 0; s < 2; s++) begin
      rd = !pins[s].semaphore_select_n && !pins[s].oe_n;
      if (rd && !rd_q[s]) lat[s] = {16{own[pins[s].addr[2:0]] != 2'(s + 1)}};
      rd_q[s] = rd;
      // Released bus shows the inverse, not a stale value
      rdata[s] <= rd ? lat[s] : ~lat[s];
    end
  end
endmodule
